// ### nfc_cfg.svh
// Constants for the numeric format converter
// Assumes inclusion by bare name from the converter package and module
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH
// Real format field layout
`define NFC_SGL_EXP_W    8
`define NFC_DBL_EXP_W    11
`define NFC_EXT_EXP_W    15
`define NFC_SGL_FRAC_W   23
`define NFC_DBL_FRAC_W   52
`define NFC_EXT_FRAC_W   63
`define NFC_SGL_BIAS     127
`define NFC_DBL_BIAS     1023
`define NFC_EXT_BIAS     16383
// Packed decimal layout
`define NFC_BCD_DIGITS   18
`define NFC_BCD_SIGN_BIT 79
// Format select codes
`define NFC_FMT_W16      3'h0
`define NFC_FMT_W32      3'h1
`define NFC_FMT_W64      3'h2
`define NFC_FMT_BCD      3'h3
`define NFC_FMT_SGL      3'h4
`define NFC_FMT_DBL      3'h5
`define NFC_FMT_EXT      3'h6
`endif

// ### nfc_pkg.sv
// Types of the numeric format converter
// Assumes nfc_cfg.svh on the include path
`include "nfc_cfg.svh"
package nfc_pkg;
  typedef logic [2:0] nfc_fmt_t;
  typedef struct packed {
    logic        sign;
    logic [14:0] exp;
    logic [63:0] sig;
  } nfc_ext_t;
  typedef struct packed {
    nfc_fmt_t    fmt;
    logic [79:0] data;
  } nfc_req_t;
  typedef enum logic [1:0] {
    NFC_IDLE = 2'b00,
    NFC_BCD  = 2'b01,
    NFC_NORM = 2'b10,
    NFC_DONE = 2'b11
  } nfc_state_t;
endpackage : nfc_pkg

// ### nfc_convert.sv
// Memory operand to 80-bit extended real converter
// Assumes same-clock requester; operand bytes already assembled, sign byte highest
//
// Overview of operation
// RULE_01: Integer top bit is the sign, 1 negative
// RULE_02: Negative integers taken as two's complement
// RULE_03: Integer zero is all bits clear
// RULE_04: Word, short and long integer widths supported
// RULE_05: Integers convert exactly into extended real
// RULE_06: Eighteen BCD digits, sign bit 79, magnitude form
// RULE_07: Supplier keeps every BCD digit within 0-9
// RULE_08: Unused BCD bits ignored on load
// RULE_09: BCD converts exactly into extended real
// RULE_10: Real widths 32, 64, 80 bits
// RULE_11: Precision 24, 53, 64 bits
// RULE_12: Exponent widths 8, 11, 15 bits
// RULE_13: Stored exponent is true exponent plus bias
// RULE_14: Real sign at top bit only
// RULE_15: Normalized reals hold integer bit one
// RULE_16: Sign byte sits at highest address
// RULE_17: Single, double integer bit implied, not stored
// RULE_18: Integer and BCD results normalized
`timescale 1ns/1ns
`include "nfc_cfg.svh"
module nfc_convert #(
  // Operand and result geometry
  parameter int OPD_W      = 80,
  parameter int EXP_W      = `NFC_EXT_EXP_W,
  parameter int SIG_W      = `NFC_EXT_FRAC_W + 1,
  parameter int BCD_DIGITS = `NFC_BCD_DIGITS
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // Request
  input  wire logic              req_valid_i,
  input  wire nfc_pkg::nfc_req_t req_i,
  output logic                   req_ready_o,
  // Result
  output logic                   res_valid_o,
  output nfc_pkg::nfc_ext_t      res_o
);
  import nfc_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (OPD_W != 80) begin : g_bad_opd
    $error("Operand width must be 80");
  end
  if (EXP_W != 15) begin : g_bad_exp
    $error("Extended exponent width must be 15");
  end
  if (SIG_W != 64) begin : g_bad_sig
    $error("Extended significand width must be 64");
  end
  if (BCD_DIGITS != 18) begin : g_bad_bcd
    $error("Packed decimal operand must hold 18 digits");
  end

  // ---------------------------------------------------------------
  // Operand decode
  // ---------------------------------------------------------------
  logic [79:0] opd;
  nfc_fmt_t    fmt;
  assign opd = req_i.data;
  assign fmt = req_i.fmt;

  // Integer sign and magnitude
  wire        w16_neg = opd[15];                                   // RULE_01
  wire        w32_neg = opd[31];                                   // RULE_01
  wire        w64_neg = opd[63];                                   // RULE_01
  wire [63:0] w16_mag = w16_neg ? 64'(-{{48{1'b1}}, opd[15:0]})
                                : {48'h0, opd[15:0]};              // RULE_02 RULE_04
  wire [63:0] w32_mag = w32_neg ? 64'(-{{32{1'b1}}, opd[31:0]})
                                : {32'h0, opd[31:0]};              // RULE_02 RULE_04
  wire [63:0] w64_mag = w64_neg ? 64'(-opd[63:0]) : opd[63:0];     // RULE_02 RULE_04

  // Single real fields, sign at bit 31
  wire        sgl_s   = opd[31];                                   // RULE_14 RULE_10
  wire [7:0]  sgl_e   = opd[30:23];                                // RULE_12
  wire [22:0] sgl_f   = opd[22:0];                                 // RULE_15 RULE_11
  wire        sgl_j   = (sgl_e != 8'h0);                           // RULE_17
  // Double real fields, sign at bit 63
  wire        dbl_s   = opd[63];                                   // RULE_14 RULE_10
  wire [10:0] dbl_e   = opd[62:52];                                // RULE_12
  wire [51:0] dbl_f   = opd[51:0];                                 // RULE_15 RULE_11
  wire        dbl_j   = (dbl_e != 11'h0);                          // RULE_17

  // Rebias to extended exponent
  wire [14:0] sgl_xe = (sgl_e == 8'hff) ? 15'h7fff :
                       (sgl_e == 8'h0) ? 15'h0 :
                       15'(sgl_e) + 15'(`NFC_EXT_BIAS - `NFC_SGL_BIAS);  // RULE_13
  wire [14:0] dbl_xe = (dbl_e == 11'h7ff) ? 15'h7fff :
                       (dbl_e == 11'h0) ? 15'h0 :
                       15'(dbl_e) + 15'(`NFC_EXT_BIAS - `NFC_DBL_BIAS);  // RULE_13

  // Real results are immediate
  wire nfc_ext_t sgl_r = '{sign: sgl_s, exp: sgl_xe,
                           sig: {sgl_j, sgl_f, 40'h0}};            // RULE_17
  wire nfc_ext_t dbl_r = '{sign: dbl_s, exp: dbl_xe,
                           sig: {dbl_j, dbl_f, 11'h0}};            // RULE_17
  wire nfc_ext_t ext_r = '{sign: opd[79], exp: opd[78:64],
                           sig: opd[63:0]};                        // RULE_10 RULE_14

  wire is_int  = (fmt == `NFC_FMT_W16) || (fmt == `NFC_FMT_W32) || (fmt == `NFC_FMT_W64);
  wire is_bcd  = (fmt == `NFC_FMT_BCD);
  wire [63:0] int_mag = (fmt == `NFC_FMT_W16) ? w16_mag :
                        (fmt == `NFC_FMT_W32) ? w32_mag : w64_mag;
  wire        int_neg = (fmt == `NFC_FMT_W16) ? w16_neg :
                        (fmt == `NFC_FMT_W32) ? w32_neg : w64_neg;
  wire nfc_ext_t real_r = (fmt == `NFC_FMT_SGL) ? sgl_r :
                          (fmt == `NFC_FMT_DBL) ? dbl_r : ext_r;

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  nfc_state_t  st_q, st_d;
  logic [63:0] acc_q, acc_d;
  logic [71:0] dig_q, dig_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        sgn_q, sgn_d;
  logic [14:0] exp_q, exp_d;
  logic        rdy_q, rdy_d;
  logic        vld_q, vld_d;
  nfc_ext_t    res_q, res_d;

  // Decimal step: acc*10 + next digit, top digit first
  wire [63:0] acc_x10 = 64'({acc_q, 3'b000} + {acc_q, 1'b0});
  wire [63:0] bcd_nxt = acc_x10 + {60'h0, dig_q[71:68]};           // RULE_09
  wire        acc_zero = (acc_q == 64'h0);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d  = st_q;
    acc_d = acc_q;
    dig_d = dig_q;
    cnt_d = cnt_q;
    sgn_d = sgn_q;
    exp_d = exp_q;
    rdy_d = rdy_q;
    vld_d = 1'b0;
    res_d = res_q;
    case (st_q)
      NFC_IDLE: begin
        if (req_valid_i && rdy_q) begin
          if (is_int) begin
            acc_d = int_mag;                                       // RULE_05
            sgn_d = int_neg;
            exp_d = 15'(`NFC_EXT_BIAS + 63);
            rdy_d = 1'b0;
            st_d  = NFC_NORM;
          end else if (is_bcd) begin
            acc_d = 64'h0;
            dig_d = opd[71:0];                                     // RULE_08 RULE_07
            sgn_d = opd[`NFC_BCD_SIGN_BIT];                        // RULE_06 RULE_16
            cnt_d = 5'(BCD_DIGITS);
            exp_d = 15'(`NFC_EXT_BIAS + 63);
            rdy_d = 1'b0;
            st_d  = NFC_BCD;
          end else begin
            res_d = real_r;
            vld_d = 1'b1;
          end
        end
      end
      NFC_BCD: begin
        acc_d = bcd_nxt;                                           // RULE_06
        dig_d = {dig_q[67:0], 4'h0};
        cnt_d = cnt_q - 5'h1;
        if (cnt_q == 5'h1) begin
          st_d = NFC_NORM;
        end
      end
      NFC_NORM: begin
        if (acc_zero) begin
          res_d = '{sign: 1'b0, exp: 15'h0, sig: 64'h0};           // RULE_03
          st_d  = NFC_DONE;
        end else if (acc_q[63]) begin
          res_d = '{sign: sgn_q, exp: exp_q, sig: acc_q};          // RULE_18 RULE_15
          st_d  = NFC_DONE;
        end else begin
          acc_d = {acc_q[62:0], 1'b0};                             // RULE_18
          exp_d = exp_q - 15'h1;
        end
      end
      NFC_DONE: begin
        vld_d = 1'b1;
        rdy_d = 1'b1;
        st_d  = NFC_IDLE;
      end
      default: begin
        st_d  = NFC_IDLE;
        rdy_d = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q  <= NFC_IDLE;
      acc_q <= 64'h0;
      dig_q <= 72'h0;
      cnt_q <= 5'h0;
      sgn_q <= 1'b0;
      exp_q <= 15'h0;
      rdy_q <= 1'b1;
      vld_q <= 1'b0;
      res_q <= '0;
    end else begin
      st_q  <= st_d;
      acc_q <= acc_d;
      dig_q <= dig_d;
      cnt_q <= cnt_d;
      sgn_q <= sgn_d;
      exp_q <= exp_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
      res_q <= res_d;
    end
  end

  assign req_ready_o = rdy_q;
  assign res_valid_o = vld_q;
  assign res_o       = res_q;

endmodule : nfc_convert

// ### nfc_convert_props.sv
// Checker on the converter ports
// Assumes bind to nfc_convert, one clock
`timescale 1ns/1ns
module nfc_convert_props (
  input wire logic              ref_clk_i,
  input wire logic              rst_n_i,
  input wire logic              req_valid_i,
  input wire nfc_pkg::nfc_req_t req_i,
  input wire logic              req_ready_o,
  input wire logic              res_valid_o,
  input wire nfc_pkg::nfc_ext_t res_o
);
  import nfc_pkg::*;
  logic take;
  logic slow_q;
  assign take = req_valid_i && req_ready_o;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) slow_q <= 1'b0;
    else if (take) slow_q <= req_i.fmt < 3'h4;
    else if (res_valid_o) slow_q <= 1'b0;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence real_s; take && req_i.fmt >= 3'h4; endsequence
  sequence int_s; take && req_i.fmt < 3'h3; endsequence
  sequence bcd_s; take && req_i.fmt == 3'h3; endsequence
  real_lat_a: assert property (real_s |=> res_valid_o)
    else $error("real late");
  int_lat_a: assert property (int_s |=> !res_valid_o ##[1:65] res_valid_o)
    else $error("int latency");
  bcd_lat_a: assert property (bcd_s |=> !res_valid_o[*8] ##[12:76] res_valid_o)
    else $error("bcd latency");
  busy_low_a: assert property (take && req_i.fmt < 3'h4 |=> !req_ready_o)
    else $error("ready stayed");
  ready_pair_a: assert property ($rose(req_ready_o) |-> res_valid_o)
    else $error("ready unpaired");
  ext_pass_a: assert property (take && req_i.fmt == 3'h6 |=> res_o == $past(req_i.data))
    else $error("ext altered");
  sgl_field_a: assert property (take && req_i.fmt == 3'h4 |=>
    res_o.sign == $past(req_i.data[31]) && res_o.sig[62:40] == $past(req_i.data[22:0]))
    else $error("single fields");
  int_norm_a: assert property (res_valid_o && slow_q |-> res_o.sig[63] || res_o == '0)
    else $error("not normalized");
endmodule : nfc_convert_props

// ### nfc_host.sv
// Host operand source model
// Assumes bench calls send; sign byte in top bits
`timescale 1ns/1ns
module nfc_host (
  input  wire logic         ref_clk_i,
  input  wire logic         req_ready_i,
  output logic              req_valid_o,
  output nfc_pkg::nfc_req_t req_o
);
  import nfc_pkg::*;
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  // Hold until taken or 200 cycles pass, then scramble released data
  task automatic send(input nfc_fmt_t f, input logic [79:0] d, output bit ok);
    ok = 1'b0;
    @(posedge ref_clk_i);
    #2;
    req_valid_o = 1'b1;
    req_o = {f, d};
    for (int i = 0; i < 200 && !ok; i++) begin
      @(posedge ref_clk_i);
      ok = req_ready_i;
    end
    #2;
    req_valid_o = 1'b0;
    req_o = ~req_o;
  endtask : send
endmodule : nfc_host

// ### nfc_convert_tb_top.sv
// Self-checking bench for the converter
// Assumes nfc_host drives requests; checker bound below
`timescale 1ns/1ns
module nfc_convert_tb_top;
  import nfc_pkg::*;
  logic        ref_clk_i, rst_n_i, req_valid_i, req_ready_o, res_valid_o;
  nfc_req_t    req_i;
  nfc_ext_t    res_o;
  nfc_fmt_t    f;
  logic [79:0] d;
  logic [31:0] lf;
  int          fails, cmp_count;
  nfc_convert nfc_convert_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .res_valid_o(res_valid_o), .res_o(res_o));
  nfc_host nfc_host_inst (.ref_clk_i(ref_clk_i), .req_ready_i(req_ready_o),
    .req_valid_o(req_valid_i), .req_o(req_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] lfsr_f(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_f
  function automatic nfc_ext_t exp_f(nfc_fmt_t g, logic [79:0] v);
    logic [63:0] m;
    logic [7:0]  e8;
    logic [10:0] e11;
    logic        s;
    int          e;
    m = 64'h0;
    e = 63;
    e8 = v[30:23];
    e11 = v[62:52];
    case (g)
      3'h0: m = 64'($signed(v[15:0]));
      3'h1: m = 64'($signed(v[31:0]));
      3'h2: m = v[63:0];
      3'h3: for (int i = 17; i >= 0; i--) m = m * 64'ha + 64'(v[i*4+:4]);
      3'h4: return {v[31], (e8 == 8'hff ? 15'h7fff : e8 == 8'h0 ? 15'h0 : 15'(e8) + 15'h3f80),
        e8 != 8'h0, v[22:0], 40'h0};
      3'h5: return {v[63], (e11 == 11'h7ff ? 15'h7fff : e11 == 11'h0 ? 15'h0 :
        15'(e11) + 15'h3c00), e11 != 11'h0, v[51:0], 11'h0};
      default: return v;
    endcase
    s = g == 3'h3 ? v[79] : m[63];
    if (g != 3'h3 && m[63]) m = -m;
    if (m == 64'h0) return '0;
    while (!m[63]) begin
      m = m << 1;
      e--;
    end
    return {s, 15'(16383 + e), m};
  endfunction : exp_f
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic run(input nfc_fmt_t g, input logic [79:0] v);
    bit       ok;
    nfc_ext_t x;
    x = exp_f(g, v);
    nfc_host_inst.send(g, v, ok);
    for (int i = 0; i < 100 && ok && !res_valid_o; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
    cmp_count++;
    if (!ok || res_valid_o !== 1'b1 || res_o !== x) begin
      fails++;
      $display("unexpected at %0t: fmt %0d data %h got %h", $time, g, v, res_o);
    end
    if (!ok || res_valid_o !== 1'b1) wrap_up();
  endtask : run
  initial begin
    rst_n_i = 1'b0;
    fails = 0;
    cmp_count = 0;
    lf = 32'hff23;
    repeat (12) @(posedge ref_clk_i);
    #2;
    rst_n_i = 1'b1;
    run(3'h0, 80'h1);
    run(3'h0, 80'h8000);
    run(3'h1, 80'hffff_ffff);
    run(3'h2, 80'h0);
    run(3'h2, 80'h8000_0000_0000_0000);
    run(3'h3, 80'hfe99_9999_9999_9999_9999);
    run(3'h3, 80'h8000_0000_0000_0000_0000);
    run(3'h4, 80'h4332_2000);
    run(3'h4, 80'hc332_2000);
    run(3'h4, 80'h0040_0000);
    run(3'h5, 80'h3ff0_0000_0000_0001);
    run(3'h5, 80'hfff0_0000_0000_0000);
    run(3'h6, 80'hc00f_8000_0000_0000_0001);
    run(3'h7, 80'h0001_0123_4567_89ab_cdef);
    for (int n = 0; n < 80; n++) begin
      lf = lfsr_f(lf);
      d[79:64] = lf[15:0];
      lf = lfsr_f(lf);
      d[63:32] = lf;
      lf = lfsr_f(lf);
      d[31:0] = lf;
      f = nfc_fmt_t'(lf[6:4]);
      for (int j = 0; j < 18; j++) if (f == 3'h3 && d[j*4+:4] > 4'h9) d[j*4+:4] -= 4'h6;
      run(f, d);
    end
    wrap_up();
  end
endmodule : nfc_convert_tb_top
bind nfc_convert nfc_convert_props nfc_convert_props_inst (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
  .req_ready_o(req_ready_o), .res_valid_o(res_valid_o), .res_o(res_o));
